// ### hdl/iosr_regs.svh
// Register addresses, field positions and reset values of the isolated output serial block.
`ifndef IOSR_REGS_SVH
`define IOSR_REGS_SVH

// Address handler width and the register addresses it decodes.
`define IOSR_ADDR_W 16
`define IOSR_ADDR_RST 16'h0000
`define IOSR_ADDR_ID 16'h0000
`define IOSR_ADDR_DATA_OVR 16'h0001
`define IOSR_ADDR_PRIM 16'h0002
`define IOSR_ADDR_OMODE 16'h0003
`define IOSR_ADDR_DATA_PRI 16'h0006
`define IOSR_ADDR_PARK 16'hffff

// Output data register and channel arrangement.
`define IOSR_DATA_W 32
`define IOSR_DATA_RST 32'hffffffff
`define IOSR_NPORTS 8
`define IOSR_PORT_W 4

// Layout of the synchroniser bank in the core clock domain.
`define IOSR_SYNC_W 41
`define IOSR_SY_PAR_LO 0
`define IOSR_SY_TOG 32
`define IOSR_SY_MISO 33
`define IOSR_SY_RCLK 34
`define IOSR_SY_RLATCH 35
`define IOSR_SY_RQUAL 36
`define IOSR_SY_RIN 37
`define IOSR_SY_PRIM 38
`define IOSR_SY_QUAL 39
`define IOSR_SY_SS 40
// Reset levels match the idle pins, so no output glitches as reset ends.
`define IOSR_SYNC_RST 41'h1feffffffff

`endif

// ### hdl/iosr_pkg.sv
// Types shared by the isolated output serial block.
package iosr_pkg;
`include "iosr_regs.svh"

    // Register enabled by the address handler once the qualifier falls.
    typedef enum logic [2:0] {
        IOSR_SEL_NONE = 3'b000,
        IOSR_SEL_ID = 3'b001,
        IOSR_SEL_DATA = 3'b010,
        IOSR_SEL_PRIM = 3'b011,
        IOSR_SEL_OMODE = 3'b100,
        IOSR_SEL_PARK = 3'b101
    } iosr_sel_t;

    // State of the link-side bit catcher.
    typedef struct packed {
        logic tog;
        logic mosi;
        logic qual;
    } iosr_link_t;

    // State of the core clock domain.
    typedef struct packed {
        logic tog_d3;
        logic tog_d4;
        logic qual_d;
        logic [`IOSR_ADDR_W-1:0] addr;
        iosr_sel_t sel;
        logic [`IOSR_DATA_W-1:0] id_sh;
        logic [`IOSR_DATA_W-1:0] data_sh;
        logic pend;
        logic [`IOSR_DATA_W-1:0] latch;
        logic override;
        logic [`IOSR_DATA_W-1:0] chan;
        logic miso_oe_n;
        logic mosi_oe_n;
        logic qual_oe_n;
        logic strobe_oe_n;
        logic sclk_oe_n;
        logic rear_out;
        logic drv_lvl;
    } iosr_core_t;
endpackage

// ### hdl/iosr_bit_if.sv
// Carrier for one sampled link bit from the link clock domain to the core.
`timescale 1ns/100ps
interface iosr_bit_if;
    logic tog;
    logic mosi;
    logic qual;
    modport src (output tog, output mosi, output qual);
    modport dst (input tog, input mosi, input qual);
endinterface

// ### hdl/iosr_sync.sv
// Two-flop synchroniser bank for levels entering the core clock domain.
`timescale 1ns/100ps
module iosr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } iosr_sync_t;

    iosr_sync_t st_r;
    iosr_sync_t st_nxt;

    // The first stage feeds only the second, so metastability never reaches logic.
    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
        if (!rst_b) begin
            st_nxt.s1 = RST_VAL;
            st_nxt.s2 = RST_VAL;
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign q = st_r.s2;
endmodule

// ### hdl/iosr_link.sv
// Link-clock bit catcher that samples the master-out line and the qualifier.
`timescale 1ns/100ps
module iosr_link (
    // Link clock and slot select.
    input wire logic serial_link_clock,
    input wire logic slot_select_n,
    // Bus data and qualifier levels.
    input wire logic mosi_i,
    input wire logic link_qualifier_i,
    // Sampled bit towards the core.
    iosr_bit_if.src bit_o
);
    import iosr_pkg::*;

    iosr_link_t st_r;
    iosr_link_t st_nxt;

    // Each rising link edge captures one bit and flips the toggle the core watches.
    always_comb begin
        st_nxt.tog = ~st_r.tog;
        st_nxt.mosi = mosi_i;
        st_nxt.qual = link_qualifier_i;
    end

    // A high slot select holds the catcher cleared, so no bit is taken outside a frame.
    always_ff @(posedge serial_link_clock or posedge slot_select_n) begin
        if (slot_select_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bit_o.tog = st_r.tog;
    assign bit_o.mosi = st_r.mosi;
    assign bit_o.qual = st_r.qual;
endmodule

// ### hdl/iosr_top.sv
// Serial register interface and output routing of the 32-channel isolated output module.
//
// Behaviour
// [RL1] Low module reset returns registers, modes and routing to the power-up state.
// [RL2] Link shifting and reading happen only while slot select is low.
// [RL3] Qualifier high marks address bits, low marks data bits for the selected register.
// [RL4] Link clock idles high; both directions are sampled on its rising edge.
// [RL5] Master selects a slot with the strobe low and a 16-bit slot number.
// [RL6] Serial primary mode bridges rear signals to the bus; parallel feeds the router.
// [RL7] Serial output mode follows the data latch; parallel follows rear-connector levels.
// [RL8] Rear levels never reach the router in serial primary mode.
// [RL9] Data register shifts bits in only with select low, qualifier low, data address.
// [RL10] Address 0001 forces serial output mode; 0006 returns to the primary mode.
// [RL11] Master writes address, drops qualifier, clocks data, then raises select and qualifier.
// [RL12] Shifted data reaches the outputs when select and qualifier are both high again.
// [RL13] Address 0000 shifts the four identification bytes onto master-in.
// [RL14] After four bytes only zeros go out until deselection reloads the code.
// [RL15] Address 0003 with qualifier low shows output mode: high serial, low parallel.
// [RL16] Address 0002 with qualifier low shows primary mode: low serial, high parallel.
// [RL17] Thirty-two outputs in eight ports of four, all from the selected source.
// [RL18] Address handler shifts two bytes MSB first; qualifier fall enables the register.
// [RL19] Reset and power-up set every data register bit high.
// [RL20] Identification goes out least significant byte first, each byte MSB first.
// [RL21] Data register takes bit 31 first and bit 0 last.
// [RL22] Latched data bit n drives output channel n.
`timescale 1ns/100ps
`include "iosr_regs.svh"
module iosr_top #(
    // Identification code; this value is arbitrary.
    parameter logic [31:0] MODULE_ID_CODE = 32'h5a3c0f01
) (
    // Core clock and module reset.
    input wire logic clk,
    input wire logic rst_b,
    // Bus link clock, also the clock of the bit catcher.
    input wire logic serial_link_clock,
    output logic serial_link_clock_o,
    output logic serial_link_clock_oe_n,
    // Bus slot select.
    input wire logic slot_select_n,
    // Bus master-out line.
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_n,
    // Bus master-in line.
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_n,
    // Bus data/address qualifier.
    input wire logic link_qualifier_i,
    output logic link_qualifier_o,
    output logic link_qualifier_oe_n,
    // Bus slot-latch strobe.
    input wire logic slot_latch_strobe_n_i,
    output logic slot_latch_strobe_n_o,
    output logic slot_latch_strobe_n_oe_n,
    // Rear connector serial signals.
    input wire logic rear_serial_in,
    input wire logic rear_qualifier_n,
    input wire logic rear_slot_latch_n,
    input wire logic rear_serial_clock,
    output logic rear_serial_out,
    // Rear connector parallel levels and the primary mode jumper.
    input wire logic [31:0] rear_parallel_in,
    input wire logic primary_parallel,
    // Output channels.
    output logic [31:0] channel_out
);
    import iosr_pkg::*;

    iosr_core_t st_r;
    iosr_core_t st_nxt;
    iosr_bit_if link_bit ();

    logic [`IOSR_SYNC_W-1:0] sync_d;
    logic [`IOSR_SYNC_W-1:0] sync_q;
    logic [31:0] rear_par_s;
    logic [31:0] chan_src;
    logic tog_s;
    logic ss_s;
    logic qual_s;
    logic prim_s;
    logic rin_s;
    logic rqual_s;
    logic rlatch_s;
    logic rclk_s;
    logic miso_s;
    logic out_serial;
    logic [31:0] id_load;

    // Link-side logic runs on the bus clock and is cleared by slot select.
    iosr_link u_link (
        .serial_link_clock(serial_link_clock), // RL4
        .slot_select_n(slot_select_n), // RL2
        .mosi_i(mosi_i),
        .link_qualifier_i(link_qualifier_i),
        .bit_o(link_bit.src)
    );

    // These pin levels and the bit toggle pass two flops; the caught master-out bit and qualifier are read directly.
    assign sync_d = {slot_select_n, link_qualifier_i, primary_parallel, rear_serial_in,
                     rear_qualifier_n, rear_slot_latch_n, rear_serial_clock, miso_i,
                     link_bit.tog, rear_parallel_in};

    iosr_sync #(
        .W(`IOSR_SYNC_W),
        .RST_VAL(`IOSR_SYNC_RST)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(sync_d),
        .q(sync_q)
    );

    // Named views of the synchronised bank.
    assign rear_par_s = sync_q[`IOSR_SY_PAR_LO +: 32];
    assign tog_s = sync_q[`IOSR_SY_TOG];
    assign miso_s = sync_q[`IOSR_SY_MISO];
    assign rclk_s = sync_q[`IOSR_SY_RCLK];
    assign rlatch_s = sync_q[`IOSR_SY_RLATCH];
    assign rqual_s = sync_q[`IOSR_SY_RQUAL];
    assign rin_s = sync_q[`IOSR_SY_RIN];
    assign prim_s = sync_q[`IOSR_SY_PRIM];
    assign qual_s = sync_q[`IOSR_SY_QUAL];
    assign ss_s = sync_q[`IOSR_SY_SS];

    // Code laid out so that shifting MSB first sends byte 0 first, each byte MSB first.
    assign id_load = {MODULE_ID_CODE[7:0], MODULE_ID_CODE[15:8],
                      MODULE_ID_CODE[23:16], MODULE_ID_CODE[31:24]}; // RL20

    // Output mode is serial when overridden or when the jumper selects serial primary mode.
    assign out_serial = st_r.override | ~prim_s; // RL8

    // Each port of four channels picks its source from the current output mode.
    genvar gp;
    generate
        for (gp = 0; gp < `IOSR_NPORTS; gp = gp + 1) begin : g_port
            // Latched bit n drives channel n; rear levels only when the router owns them.
            assign chan_src[gp*`IOSR_PORT_W +: `IOSR_PORT_W] = out_serial ?
                st_r.latch[gp*`IOSR_PORT_W +: `IOSR_PORT_W] :
                rear_par_s[gp*`IOSR_PORT_W +: `IOSR_PORT_W]; // RL7 RL17 RL22
        end
    endgenerate

    // Next-state logic of the core domain.
    always_comb begin
        logic bit_ev;
        logic qual_fall;
        logic qual_rise;
        logic drive;
        logic val;
        st_nxt = st_r;
        bit_ev = 1'b0;
        qual_fall = 1'b0;
        qual_rise = 1'b0;
        drive = 1'b0;
        val = 1'b1;

        // The extra toggle stage delays a bit until slot select is known, so the catcher
        // clearing at the end of a frame is never taken for a new bit.
        st_nxt.tog_d3 = tog_s;
        st_nxt.tog_d4 = st_r.tog_d3;
        st_nxt.qual_d = qual_s;
        bit_ev = (st_r.tog_d3 ^ st_r.tog_d4) & ~ss_s; // RL2
        qual_fall = st_r.qual_d & ~qual_s & ~ss_s;
        qual_rise = ~st_r.qual_d & qual_s;

        // Each caught bit goes to the address handler or to the enabled register.
        if (bit_ev) begin
            if (link_bit.qual) begin
                st_nxt.addr = {st_r.addr[`IOSR_ADDR_W-2:0], link_bit.mosi}; // RL3 RL18
            end else begin
                unique case (st_r.sel)
                    IOSR_SEL_ID: begin
                        st_nxt.id_sh = {st_r.id_sh[`IOSR_DATA_W-2:0], 1'b0}; // RL14
                    end
                    IOSR_SEL_DATA: begin
                        st_nxt.data_sh = {st_r.data_sh[`IOSR_DATA_W-2:0],
                                          link_bit.mosi}; // RL9 RL21
                        st_nxt.pend = 1'b1;
                    end
                    IOSR_SEL_NONE, IOSR_SEL_PRIM, IOSR_SEL_OMODE, IOSR_SEL_PARK: begin
                        st_nxt.pend = st_r.pend;
                    end
                    default: begin
                        st_nxt.sel = IOSR_SEL_NONE;
                    end
                endcase
            end
        end

        // The qualifier falling enables the addressed register and applies mode changes.
        if (qual_fall) begin
            unique case (st_nxt.addr)
                `IOSR_ADDR_ID: begin
                    st_nxt.sel = IOSR_SEL_ID;
                    st_nxt.id_sh = id_load; // RL13
                end
                `IOSR_ADDR_DATA_OVR: begin
                    st_nxt.sel = IOSR_SEL_DATA;
                    st_nxt.override = 1'b1; // RL10
                end
                `IOSR_ADDR_DATA_PRI: begin
                    st_nxt.sel = IOSR_SEL_DATA;
                    st_nxt.override = 1'b0; // RL10
                end
                `IOSR_ADDR_PRIM: begin
                    st_nxt.sel = IOSR_SEL_PRIM;
                end
                `IOSR_ADDR_OMODE: begin
                    st_nxt.sel = IOSR_SEL_OMODE;
                end
                `IOSR_ADDR_PARK: begin
                    st_nxt.sel = IOSR_SEL_PARK;
                end
                default: begin
                    st_nxt.sel = IOSR_SEL_NONE;
                end
            endcase
        end

        // The qualifier rising ends the register access; the master expects this order.
        if (qual_rise) begin
            st_nxt.sel = IOSR_SEL_NONE; // RL11
        end

        // Deselecting the module ends any access and reloads the identification code.
        if (ss_s) begin
            st_nxt.sel = IOSR_SEL_NONE;
            st_nxt.id_sh = id_load; // RL14
        end

        // The data latch keeps its old value until select and qualifier are both high.
        if (st_r.pend && ss_s && qual_s) begin
            st_nxt.latch = st_r.data_sh; // RL12
            st_nxt.pend = 1'b0;
        end

        st_nxt.chan = chan_src; // RL7

        // Master-in shows the enabled identification or status register while the qualifier is low; status bits
        // need no clocking because they are plain levels.
        if (!ss_s && !qual_s) begin
            unique case (st_nxt.sel)
                IOSR_SEL_ID: begin
                    drive = 1'b1;
                    val = st_nxt.id_sh[`IOSR_DATA_W-1]; // RL13 RL20
                end
                IOSR_SEL_PRIM: begin
                    drive = 1'b1;
                    val = prim_s; // RL16
                end
                IOSR_SEL_OMODE: begin
                    drive = 1'b1;
                    val = out_serial; // RL15
                end
                IOSR_SEL_NONE, IOSR_SEL_DATA, IOSR_SEL_PARK: begin
                    drive = 1'b0;
                end
                default: begin
                    drive = 1'b0;
                end
            endcase
        end
        // Open collector: only a low level is driven, a high one is left to the pull-up.
        st_nxt.miso_oe_n = ~(drive & ~val); // RL4

        // In serial primary mode the rear connector masters the bus lines; in parallel
        // primary mode they are released and the rear levels feed the router instead.
        st_nxt.mosi_oe_n = ~(~prim_s & ~rin_s); // RL6
        st_nxt.qual_oe_n = ~(~prim_s & ~rqual_s); // RL6
        st_nxt.strobe_oe_n = ~(~prim_s & ~rlatch_s); // RL5 RL6
        st_nxt.sclk_oe_n = ~(~prim_s & ~rclk_s); // RL6
        st_nxt.rear_out = prim_s | miso_s; // RL6
        st_nxt.drv_lvl = 1'b0;

        // Module reset brings every register back to its power-up value.
        if (!rst_b) begin
            st_nxt.tog_d3 = 1'b0;
            st_nxt.tog_d4 = 1'b0;
            st_nxt.qual_d = 1'b1;
            st_nxt.addr = `IOSR_ADDR_RST;
            st_nxt.sel = IOSR_SEL_NONE;
            st_nxt.id_sh = id_load;
            st_nxt.data_sh = `IOSR_DATA_RST; // RL19
            st_nxt.pend = 1'b0;
            st_nxt.latch = `IOSR_DATA_RST; // RL19
            st_nxt.override = 1'b0;
            st_nxt.chan = `IOSR_DATA_RST;
            st_nxt.miso_oe_n = 1'b1;
            st_nxt.mosi_oe_n = 1'b1;
            st_nxt.qual_oe_n = 1'b1;
            st_nxt.strobe_oe_n = 1'b1;
            st_nxt.sclk_oe_n = 1'b1;
            st_nxt.rear_out = 1'b1;
            st_nxt.drv_lvl = 1'b0; // RL1
        end
    end

    // State register of the core domain.
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    // Every output comes straight from the state register.
    assign channel_out = st_r.chan;
    assign miso_o = st_r.drv_lvl;
    assign miso_oe_n = st_r.miso_oe_n;
    assign mosi_o = st_r.drv_lvl;
    assign mosi_oe_n = st_r.mosi_oe_n;
    assign link_qualifier_o = st_r.drv_lvl;
    assign link_qualifier_oe_n = st_r.qual_oe_n;
    assign slot_latch_strobe_n_o = st_r.drv_lvl;
    assign slot_latch_strobe_n_oe_n = st_r.strobe_oe_n;
    assign serial_link_clock_o = st_r.drv_lvl;
    assign serial_link_clock_oe_n = st_r.sclk_oe_n;
    assign rear_serial_out = st_r.rear_out;
endmodule

// ### test/iosr_top_assertions.sv
// Concurrent checks on the ports of the isolated output serial block.
`timescale 1ns/100ps
module iosr_chk (
    // Clock, reset and mode jumper.
    input wire logic clk,
    input wire logic rst_b,
    input wire logic primary_parallel,
    // Bus levels seen by the module.
    input wire logic slot_select_n,
    input wire logic link_qualifier_i,
    // Rear connector levels.
    input wire logic rear_slot_latch_n,
    input wire logic [31:0] rear_parallel_in,
    // Module outputs.
    input wire logic miso_oe_n,
    input wire logic mosi_oe_n,
    input wire logic slot_latch_strobe_n_oe_n,
    input wire logic rear_serial_out,
    input wire logic [31:0] channel_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Reset checks carry no disable, because they look at the reset itself.
    property p_reset_chan;
        @(posedge clk) disable iff (1'b0) !rst_b |=> channel_out == 32'hffffffff;
    endproperty
    a_reset_chan: assert property (p_reset_chan)
        else $error("outputs not all high after reset");
    property p_reset_bus;
        @(posedge clk) disable iff (1'b0)
            !rst_b |=> miso_oe_n && mosi_oe_n && slot_latch_strobe_n_oe_n && rear_serial_out;
    endproperty
    a_reset_bus: assert property (p_reset_bus)
        else $error("bus lines not released after reset");

    // A deselected module must leave the master-in line alone.
    property p_ss_idle;
        slot_select_n [*5] |-> miso_oe_n;
    endproperty
    a_ss_idle: assert property (p_ss_idle)
        else $error("master-in driven while deselected");
    property p_qual_idle;
        $rose(link_qualifier_i) |-> ##[1:6] miso_oe_n;
    endproperty
    a_qual_idle: assert property (p_qual_idle)
        else $error("master-in not released after qualifier rise");

    // In serial primary mode the outputs only move when a frame ends.
    property p_frame_hold;
        (!primary_parallel && !slot_select_n) [*8] |-> $stable(channel_out);
    endproperty
    a_frame_hold: assert property (p_frame_hold)
        else $error("outputs moved during a frame");
    property p_serial_still;
        (!primary_parallel && slot_select_n) [*8] |-> $stable(channel_out);
    endproperty
    a_serial_still: assert property (p_serial_still)
        else $error("rear levels reached outputs in serial primary mode");

    // Outside frames in parallel primary mode, any output change copies the rear levels.
    property p_par_follow;
        primary_parallel && $past(primary_parallel, 8) && slot_select_n
            && $past(slot_select_n, 8) && $changed(channel_out)
            |-> channel_out == $past(rear_parallel_in, 3);
    endproperty
    a_par_follow: assert property (p_par_follow)
        else $error("outputs changed to a value other than the rear levels");

    // Rear pins are bridged to the bus only in serial primary mode.
    property p_bridge;
        (!primary_parallel && !rear_slot_latch_n) [*5] |-> !slot_latch_strobe_n_oe_n;
    endproperty
    a_bridge: assert property (p_bridge)
        else $error("rear strobe not bridged to the bus");
    property p_rear_out;
        primary_parallel [*5] |-> rear_serial_out;
    endproperty
    a_rear_out: assert property (p_rear_out)
        else $error("rear serial out driven in parallel primary mode");

    c_frame: cover property ($fell(slot_select_n));
    c_miso_low: cover property (!miso_oe_n);
    c_par_change: cover property (primary_parallel && $changed(channel_out));
endmodule

bind iosr_top iosr_chk i_chk (.clk, .rst_b, .primary_parallel, .slot_select_n,
    .link_qualifier_i, .rear_slot_latch_n, .rear_parallel_in, .miso_oe_n, .mosi_oe_n,
    .slot_latch_strobe_n_oe_n, .rear_serial_out, .channel_out);

// ### test/iosr_master.sv
// Behavioural bus master that selects the slot and runs address and register frames.
`timescale 1ns/100ps
module iosr_master #(
    // Slot number sent during slot selection; any value serves here.
    parameter logic [15:0] SLOT_NUM = 16'h0005
) (
    // Lines driven by the master; a 1 means released to the pull-up.
    output logic sclk,
    output logic ss_n,
    output logic mosi,
    output logic qual,
    output logic strobe_n,
    // Master-in wire level.
    input wire logic miso_w
);
    // Last sampled master-in bit, announced by smp_ev.
    logic smp_bit;
    event smp_ev;

    // Everything released and the clock idle high between frames.
    initial begin
        {sclk, ss_n, mosi, qual, strobe_n} = 5'h1f;
        smp_bit = 1'b0;
    end

    // Data changes with the falling edge and is taken at the rising one; reads get slack.
    task automatic shift(input logic b, input logic rd);
        mosi = b;
        sclk = 1'b0;
        #62.5;
        if (rd) begin
            smp_bit = miso_w;
            -> smp_ev;
        end
        sclk = 1'b1;
        #62.5;
        if (rd) #125;
    endtask

    // Slot selection, address bits with the qualifier high, then n register bits.
    task automatic frame(input logic [15:0] addr, input int n, input logic [63:0] d,
                         input logic rd);
        #3.1;
        strobe_n = 1'b0;
        for (int i = 15; i >= 0; i--) shift(SLOT_NUM[i], 1'b0);
        strobe_n = 1'b1;
        ss_n = 1'b0;
        mosi = 1'b1;
        #250;
        for (int i = 15; i >= 0; i--) shift(addr[i], 1'b0);
        mosi = 1'b1;
        #250 qual = 1'b0;
        #250;
        if (n == 0) begin
            smp_bit = miso_w;
            -> smp_ev;
        end
        for (int i = n - 1; i >= 0; i--) shift(d[i], rd);
        mosi = 1'b1;
        #250;
        qual = 1'b1;
        ss_n = 1'b1;
        #500;
    endtask
endmodule

// ### test/iosr_top_tb.sv
// Self-checking bench for the isolated output serial block.
`timescale 1ns/100ps
module iosr_top_tb;
    // Identification code of the device under test; this value is arbitrary.
    localparam logic [31:0] ID_CODE = 32'h3c5a96e1;
    logic clk, rst_b, primary_parallel;
    logic rear_serial_in, rear_qualifier_n, rear_slot_latch_n, rear_serial_clock;
    logic [31:0] rear_parallel_in, channel_out, d;
    logic [63:0] w;
    logic serial_link_clock_o, serial_link_clock_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
    logic link_qualifier_o, link_qualifier_oe_n, slot_latch_strobe_n_o, slot_latch_strobe_n_oe_n;
    logic rear_serial_out, m_sclk, slot_select_n, m_mosi, m_qual, m_strobe;
    logic [31:0] seed = 32'h1a889ab6;
    logic q_miso[$];
    logic [31:0] q_chan[$];
    int error_cnt = 0;
    int total_checks = 0;
    event chan_ev;
    // Open-collector wires: any party with its enable low pulls the line down.
    wire serial_link_clock = m_sclk & (serial_link_clock_oe_n | serial_link_clock_o);
    wire mosi_i = m_mosi & (mosi_oe_n | mosi_o);
    wire link_qualifier_i = m_qual & (link_qualifier_oe_n | link_qualifier_o);
    wire slot_latch_strobe_n_i = m_strobe & (slot_latch_strobe_n_oe_n | slot_latch_strobe_n_o);
    wire miso_i = miso_oe_n | miso_o;

    iosr_top #(.MODULE_ID_CODE(ID_CODE)) i_iosr_top (.clk, .rst_b, .serial_link_clock,
        .serial_link_clock_o, .serial_link_clock_oe_n, .slot_select_n, .mosi_i, .mosi_o,
        .mosi_oe_n, .miso_i, .miso_o, .miso_oe_n, .link_qualifier_i, .link_qualifier_o,
        .link_qualifier_oe_n, .slot_latch_strobe_n_i, .slot_latch_strobe_n_o,
        .slot_latch_strobe_n_oe_n, .rear_serial_in, .rear_qualifier_n, .rear_slot_latch_n,
        .rear_serial_clock, .rear_serial_out, .rear_parallel_in, .primary_parallel,
        .channel_out);
    iosr_master i_iosr_master (.sclk(m_sclk), .ss_n(slot_select_n), .mosi(m_mosi),
        .qual(m_qual), .strobe_n(m_strobe), .miso_w(miso_i));

    // Core clock at 40 MHz.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic close_out();
        if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp_chan(input logic [31:0] e);
        total_checks++;
        if (channel_out !== e) begin
            error_cnt++;
            $display("mismatch channel_out exp %h got %h", e, channel_out);
        end
    endtask

    task automatic cmp_miso(input logic e);
        total_checks++;
        if (i_iosr_master.smp_bit !== e) begin
            error_cnt++;
            $display("mismatch miso exp %b got %b", e, i_iosr_master.smp_bit);
        end
    endtask

    // Outputs are registered a few edges after the cause, so the check waits them out.
    task automatic chk_chan(input logic [31:0] e);
        q_chan.push_back(e);
        repeat (12) @(posedge clk);
        -> chan_ev;
    endtask

    task automatic status(input logic [15:0] a, input logic e);
        q_miso.push_back(e);
        i_iosr_master.frame(a, 0, 64'h0, 1'b0);
    endtask

    // Watchers: each result seen takes the oldest expectation of its kind.
    always @(chan_ev) cmp_chan(q_chan.pop_front());
    always @(i_iosr_master.smp_ev) cmp_miso(q_miso.pop_front());

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        close_out();
    end

    initial begin
        rst_b = 1'b0;
        primary_parallel = 1'b0;
        {rear_serial_in, rear_qualifier_n, rear_slot_latch_n, rear_serial_clock} = 4'hf;
        rear_parallel_in = 32'h0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        chk_chan(32'hffffffff);
        // Serial primary: 0001, then an over-long 0006 write where the last 32 bits win.
        for (int a = 0; a < 2; a++) begin
            w = {rnd(), rnd()};
            i_iosr_master.frame(a ? 16'h0006 : 16'h0001, 32 + 8 * a, w, 1'b0);
            chk_chan(w[31:0]);
        end
        status(16'h0003, 1'b1);
        status(16'h0002, 1'b0);
        // Identification twice: deselection must reload the code.
        repeat (2) begin
            for (int k = 0; k < 40; k++)
                q_miso.push_back(k < 32 ? ID_CODE[8 * (k / 8) + 7 - k % 8] : 1'b0);
            i_iosr_master.frame(16'h0000, 40, 64'h0, 1'b1);
        end
        @(posedge clk);
        primary_parallel <= 1'b1;
        d = rnd();
        rear_parallel_in <= d;
        chk_chan(d);
        status(16'h0003, 1'b0);
        status(16'h0002, 1'b1);
        w = {32'h0, rnd()};
        i_iosr_master.frame(16'h0001, 32, w, 1'b0);
        chk_chan(w[31:0]);
        status(16'h0003, 1'b1);
        w = {rnd(), rnd()};
        i_iosr_master.frame(16'h0006, 32, w, 1'b0);
        @(posedge clk);
        d = rnd();
        rear_parallel_in <= d;
        chk_chan(d);
        // Back to serial primary: rear levels are cut off and the rear strobe is bridged.
        @(posedge clk);
        primary_parallel <= 1'b0;
        rear_parallel_in <= ~d;
        rear_slot_latch_n <= 1'b0;
        chk_chan(w[31:0]);
        rear_slot_latch_n <= 1'b1;
        repeat (8) @(posedge clk);
        // A reset in mid-run must bring the outputs back high.
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        chk_chan(32'hffffffff);
        @(posedge clk);
        close_out();
    end
endmodule
